// >>> include/pod_pkg.sv
// package: constants and carrier types for the pll output select and phase detect block
package pod_pkg;
    localparam int REF_CNT_W = 13;
    localparam int MAIN_CNT_W = 12;
    localparam int SWALLOW_W = 6;
    localparam int PRESCALE_RATIO = 64;
    localparam logic [12:0] REF_DIV_MIN = 13'h0005;
    localparam logic [12:0] REF_DIV_BYPASS = 13'h0001;
    localparam int SHIFT_STAGES = 25;
    localparam logic [1:0] OSEL_REF = 2'h3;
    localparam logic [1:0] OSEL_VCO = 2'h2;
    localparam logic [1:0] OSEL_SERIAL = 2'h1;
    localparam logic [1:0] OSEL_PORT = 2'h0;
    localparam logic [1:0] OSEL_RESET = OSEL_SERIAL;
    localparam logic [2:0] RMODE_XTAL_OFF = 3'h0;
    localparam logic [2:0] RMODE_XTAL_ON = 3'h1;
    localparam logic [2:0] RMODE_OUT_OFF = 3'h2;
    localparam logic [2:0] RMODE_DIV1 = 3'h3;
    localparam logic [2:0] RMODE_DIV2 = 3'h4;
    localparam logic [2:0] RMODE_DIV4 = 3'h5;
    localparam logic [2:0] RMODE_DIV8 = 3'h6;
    localparam logic [2:0] RMODE_DIV16 = 3'h7;
    localparam logic [2:0] RMODE_RESET = RMODE_DIV8;
    localparam logic [3:0] REF_OUTPUT_CNT_RESET = 4'h0;
    localparam int PD_RESET_NS = 10;
    localparam int CLK_PERIOD_NS = 5;
    localparam int PD_RESET_CYC = (PD_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] PCT_SEL_RESET = 2'h3;

    typedef struct packed {
        logic polarity_bit;
        logic detector_select_bit;
        logic standby_bit;
        logic current_level_hi;
        logic current_level_lo;
        logic port_bit;
        logic open_drain_bit;
    } pod_cfg_t;

    typedef struct packed {
        logic       pump_up;
        logic       pump_dn;
        logic [6:0] current_pct;
    } pod_pump_t;

    typedef enum logic [2:0] {
        PD_IDLE  = 3'b001,
        PD_FLAGS = 3'b010,
        PD_CLEAR = 3'b100
    } pod_pd_state_t;
endpackage : pod_pkg

// >>> src/pod_sync.sv
// three-stage input synchroniser for asynchronous pins
`timescale 1ns/1ps
module pod_sync
    import pod_pkg::*;
#(
    parameter int W = 1
)(
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // s1 is read only by s2; a change counts once s2 and s3 agree
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            dout   <= '0;
        end
        else
        begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < W; i++)
            begin
                if (s2_reg[i] == s3_reg[i])
                begin
                    dout[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule : pod_sync

// >>> src/pod_top.sv
// pll digital outputs: output mux, open-drain out, reference divider, phase detectors
// Notes on behaviour
// - two select bits pick ref pulse, vco pulse, serial out or port bit
// - ref pulse from 13-bit counter, ratio 5..8191, rests low, pulses high
// - divide value 1 passes reference input straight to detectors
// - vco pulse from 12-bit main counter; ratio main*64 plus swallow
// - serial selection shows last shift stage, changing on serial clock fall
// - serial-out is the selection after reset
// - port selection drives the port bit level
// - open-drain output pulls low on bit 0, floats on bit 1
// - reset forces open-drain output low
// - mode 001 runs oscillator and divides; standby stops counter only
// - mode 000 stops oscillator regardless of standby
// - mode 7 gives reference output at input divided by 16
// - mode 3 gives reference output one-to-one
// - reset sets reference output ratio to eight
// - mode 2 keeps input working with reference output disabled
// - single detector tri-state; sinks when vco leads, polarity swaps
// - single detector floats when deselected or in standby
// - two bits choose single detector current; gain is current over two pi
// - double outputs rest high, pulse low per lead/lag, polarity swaps
// - double outputs held high when disabled or in standby
// - current bits give 70-100% or, with port bit high and port not selected, 25-100%
// - select bit high enables single, low enables double; resets low
// - polarity resets low; high inverts single and swaps double
`timescale 1ns/1ps
module pod_top
    import pod_pkg::*;
#(
    parameter int REF_W  = REF_CNT_W,
    parameter int MAIN_W = MAIN_CNT_W
)(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              ref_input,
    input  wire logic              rf_input,
    input  wire logic              serial_clk,
    input  wire logic              serial_last_stage,
    input  wire pod_cfg_t          cfg,
    input  wire logic              out_sel_high_bit,
    input  wire logic              out_sel_low_bit,
    input  wire logic [2:0]        ref_mode,
    input  wire logic [REF_W-1:0]  ref_div,
    input  wire logic [MAIN_W-1:0] main_div,
    input  wire logic [SWALLOW_W-1:0] swallow_div,
    output logic                   cfg_out,
    output logic                   od_out,
    output logic                   od_oe_n,
    output logic                   ref_output,
    output logic                   osc_run,
    output logic                   single_detector_out,
    output logic                   single_detector_oe_n,
    output logic [6:0]             single_current_pct,
    output logic                   det_ref_n,
    output logic                   det_vco_n
);
    localparam int SW_W = SWALLOW_W;

    // pins from outside: ref_input, rf_input, serial clock and data
    logic [3:0] pin_s;
    pod_sync #(.W(4)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .din      ({ref_input, rf_input, serial_clk, serial_last_stage}),
        .dout     (pin_s)
    );
    logic ref_s, rf_s, sclk_s, sdat_s;
    assign ref_s  = pin_s[3];
    assign rf_s   = pin_s[2];
    assign sclk_s = pin_s[1];
    assign sdat_s = pin_s[0];

    logic ref_prev_reg, rf_prev_reg, sclk_prev_reg;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ref_prev_reg  <= 1'b0;
            rf_prev_reg   <= 1'b0;
            sclk_prev_reg <= 1'b0;
        end
        else
        begin
            ref_prev_reg  <= ref_s;
            rf_prev_reg   <= rf_s;
            sclk_prev_reg <= sclk_s;
        end
    end
    logic ref_rise, rf_rise, sclk_fall;
    assign ref_rise  = ref_s & ~ref_prev_reg;
    assign rf_rise   = rf_s & ~rf_prev_reg;
    assign sclk_fall = ~sclk_s & sclk_prev_reg;

    logic standby;
    assign standby = cfg.standby_bit;

    // oscillator runs in every mode except shutdown crystal
    logic osc_on;
    assign osc_on = (ref_mode != RMODE_XTAL_OFF);

    // reference counter; standby stops it but not the oscillator
    logic [REF_W-1:0] ref_cnt_reg;
    logic             ref_pulse_reg;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ref_cnt_reg   <= '0;
            ref_pulse_reg <= 1'b0;
        end
        else if (!osc_on || standby)
        begin
            ref_pulse_reg <= 1'b0;
        end
        else if (ref_div == REF_W'(REF_DIV_BYPASS))
        begin
            ref_pulse_reg <= ref_s;
        end
        else if (ref_rise)
        begin
            // ratios below the minimum are clamped to it; the counter cannot divide lower
            if (ref_cnt_reg >= ((ref_div < REF_W'(REF_DIV_MIN)) ? REF_W'(REF_DIV_MIN) : ref_div) - REF_W'(1))
            begin
                ref_cnt_reg   <= '0;
                ref_pulse_reg <= 1'b1;
            end
            else
            begin
                ref_cnt_reg   <= ref_cnt_reg + REF_W'(1);
                ref_pulse_reg <= 1'b0;
            end
        end
        else if (ref_pulse_reg && ref_div != REF_W'(REF_DIV_BYPASS))
        begin
            ref_pulse_reg <= 1'b0;
        end
    end

    // prescaler: 65 for the first swallow cycles, then 64, over main cycles
    logic [6:0]        pre_cnt_reg;
    logic [SW_W-1:0]   sw_cnt_reg;
    logic [MAIN_W-1:0] main_cnt_reg;
    logic              vco_pulse_reg;
    logic [6:0]        pre_mod;
    assign pre_mod = (sw_cnt_reg < swallow_div) ? 7'(PRESCALE_RATIO + 1) : 7'(PRESCALE_RATIO);
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pre_cnt_reg   <= '0;
            sw_cnt_reg    <= '0;
            main_cnt_reg  <= '0;
            vco_pulse_reg <= 1'b0;
        end
        else if (standby)
        begin
            vco_pulse_reg <= 1'b0;
        end
        else if (rf_rise)
        begin
            vco_pulse_reg <= 1'b0;
            if (pre_cnt_reg >= pre_mod - 7'h01)
            begin
                pre_cnt_reg <= '0;
                if (sw_cnt_reg != {SW_W{1'b1}})
                begin
                    sw_cnt_reg <= sw_cnt_reg + SW_W'(1);
                end
                if (main_cnt_reg >= main_div - MAIN_W'(1))
                begin
                    main_cnt_reg  <= '0;
                    sw_cnt_reg    <= '0;
                    vco_pulse_reg <= 1'b1;
                end
                else
                begin
                    main_cnt_reg <= main_cnt_reg + MAIN_W'(1);
                end
            end
            else
            begin
                pre_cnt_reg <= pre_cnt_reg + 7'h01;
            end
        end
        else
        begin
            vco_pulse_reg <= 1'b0;
        end
    end

    // serial data out follows the last stage on each falling serial clock
    logic sdo_reg;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sdo_reg <= 1'b0;
        end
        else if (sclk_fall)
        begin
            sdo_reg <= sdat_s;
        end
    end

    // configurable output mux
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cfg_out <= 1'b0;
        end
        else
        begin
            unique case ({out_sel_high_bit, out_sel_low_bit})
                OSEL_REF:    cfg_out <= ref_pulse_reg;
                OSEL_VCO:    cfg_out <= vco_pulse_reg;
                OSEL_SERIAL: cfg_out <= sdo_reg;
                OSEL_PORT:   cfg_out <= cfg.port_bit;
            endcase
        end
    end

    // open-drain output: low after reset, floats when bit is 1
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            od_out  <= 1'b0;
            od_oe_n <= 1'b0;
        end
        else
        begin
            od_out  <= 1'b0;
            od_oe_n <= cfg.open_drain_bit;
        end
    end

    // reference output divider, ratio eight from reset
    logic [3:0] ref_output_cnt_reg;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ref_output_cnt_reg <= REF_OUTPUT_CNT_RESET;
            ref_output     <= 1'b0;
            osc_run        <= 1'b0;
        end
        else
        begin
            osc_run <= osc_on;
            if (ref_rise)
            begin
                ref_output_cnt_reg <= ref_output_cnt_reg + 4'h1;
            end
            unique case (ref_mode)
                RMODE_DIV16: ref_output <= ref_output_cnt_reg[3];
                RMODE_DIV8:  ref_output <= ref_output_cnt_reg[2];
                RMODE_DIV4:  ref_output <= ref_output_cnt_reg[1];
                RMODE_DIV2:  ref_output <= ref_output_cnt_reg[0];
                RMODE_DIV1:  ref_output <= ref_s;
                default:     ref_output <= 1'b0;
            endcase
        end
    end

    // phase/frequency detector: two flags, joint clear after a short delay
    pod_pd_state_t pd_state_reg;
    logic          up_flag_reg, dn_flag_reg;
    logic [3:0]    clr_cnt_reg;
    logic          ref_pulse_prev_reg, vco_pulse_prev_reg;
    logic          fr_rise, fv_rise;
    assign fr_rise = ref_pulse_reg & ~ref_pulse_prev_reg;
    assign fv_rise = vco_pulse_reg & ~vco_pulse_prev_reg;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pd_state_reg       <= PD_IDLE;
            up_flag_reg        <= 1'b0;
            dn_flag_reg        <= 1'b0;
            clr_cnt_reg        <= '0;
            ref_pulse_prev_reg <= 1'b0;
            vco_pulse_prev_reg <= 1'b0;
        end
        else
        begin
            ref_pulse_prev_reg <= ref_pulse_reg;
            vco_pulse_prev_reg <= vco_pulse_reg;
            unique case (pd_state_reg)
                PD_IDLE, PD_FLAGS:
                begin
                    if (fr_rise)
                    begin
                        up_flag_reg <= 1'b1;
                    end
                    if (fv_rise)
                    begin
                        dn_flag_reg <= 1'b1;
                    end
                    if ((up_flag_reg | fr_rise) & (dn_flag_reg | fv_rise))
                    begin
                        pd_state_reg <= PD_CLEAR;
                        clr_cnt_reg  <= 4'(PD_RESET_CYC);
                    end
                    else if (fr_rise | fv_rise)
                    begin
                        pd_state_reg <= PD_FLAGS;
                    end
                end
                PD_CLEAR:
                begin
                    if (clr_cnt_reg <= 4'h1)
                    begin
                        up_flag_reg  <= 1'b0;
                        dn_flag_reg  <= 1'b0;
                        pd_state_reg <= PD_IDLE;
                    end
                    else
                    begin
                        clr_cnt_reg <= clr_cnt_reg - 4'h1;
                    end
                end
            endcase
        end
    end

    // detector outputs; ref-side lead means up, vco-side lead means down
    logic sink_req, src_req;
    assign sink_req = cfg.polarity_bit ? up_flag_reg : dn_flag_reg;
    assign src_req  = cfg.polarity_bit ? dn_flag_reg : up_flag_reg;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            single_detector_out  <= 1'b0;
            single_detector_oe_n <= 1'b1;
            det_ref_n            <= 1'b1;
            det_vco_n            <= 1'b1;
        end
        else
        begin
            // both flags set means matched: the pump floats rather than fight itself
            single_detector_out  <= src_req;
            single_detector_oe_n <= ~cfg.detector_select_bit | standby | (sink_req == src_req);
            if (!cfg.detector_select_bit && !standby)
            begin
                det_vco_n <= ~(cfg.polarity_bit ? up_flag_reg : dn_flag_reg);
                det_ref_n <= ~(cfg.polarity_bit ? dn_flag_reg : up_flag_reg);
            end
            else
            begin
                det_vco_n <= 1'b1;
                det_ref_n <= 1'b1;
            end
        end
    end

    // current level percentage; gain = current / (2*pi) outside
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            single_current_pct <= 7'h46;
        end
        else if (cfg.port_bit && ({out_sel_high_bit, out_sel_low_bit} != OSEL_PORT))
        begin
            single_current_pct <= 7'(25 * ({cfg.current_level_hi, cfg.current_level_lo} + 3'h1));
        end
        else
        begin
            single_current_pct <= 7'(70 + 10 * {cfg.current_level_hi, cfg.current_level_lo});
        end
    end

    pd_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        (pd_state_reg == PD_CLEAR) |-> ##[1:4] !up_flag_reg && !dn_flag_reg)
        else $error("detector flags not cleared");
    od_drive_a: assert property (@(posedge core_clk) disable iff (rst)
        !cfg.open_drain_bit ##1 !cfg.open_drain_bit |-> !od_oe_n && !od_out)
        else $error("open drain not pulling low");
    single_off_a: assert property (@(posedge core_clk) disable iff (rst)
        $past(standby) || $past(!cfg.detector_select_bit) |-> single_detector_oe_n)
        else $error("single detector driven while off");
    double_rest_a: assert property (@(posedge core_clk) disable iff (rst)
        $past(standby) || $past(cfg.detector_select_bit) |-> det_ref_n && det_vco_n)
        else $error("double outputs not at rest");
    port_sel_a: assert property (@(posedge core_clk) disable iff (rst)
        {out_sel_high_bit, out_sel_low_bit} == OSEL_PORT |=> cfg_out == $past(cfg.port_bit))
        else $error("port level wrong");
    ref_off_a: assert property (@(posedge core_clk) disable iff (rst)
        ref_mode == RMODE_OUT_OFF |=> !ref_output)
        else $error("reference output not disabled");
    osc_stop_a: assert property (@(posedge core_clk) disable iff (rst)
        ref_mode == RMODE_XTAL_OFF |=> !osc_run && !ref_pulse_reg)
        else $error("oscillator not stopped");
    standby_ctl_ref_a: assert property (@(posedge core_clk) disable iff (rst)
        standby && ref_mode == RMODE_XTAL_ON |=> osc_run && !ref_pulse_reg)
        else $error("standby handling wrong");
endmodule : pod_top

// >>> dv/pod_far_end.sv
// far-end model: reference oscillator and vco source ahead of the prescaler
`timescale 1ns/1ps
module pod_far_end #(
    parameter real REF_HALF_NS = 50.0,
    parameter real RF_HALF_NS  = 15.3
)(
    input  wire logic osc_run,
    output logic      ref_input,
    output logic      rf_input
);
    initial
    begin
        ref_input = 1'h0;
        rf_input  = 1'h0;
    end
    // a stopped crystal rests low instead of holding its last level
    always
    begin
        #(REF_HALF_NS);
        ref_input = osc_run ? ~ref_input : 1'h0;
    end
    // odd half period keeps the vco source unrelated in phase to the clock
    always
    begin
        #(RF_HALF_NS);
        rf_input = ~rf_input;
    end
endmodule : pod_far_end

// >>> dv/tb.sv
// self-checking bench for the pll output select and phase detect block
`timescale 1ns/1ps
module tb;
    import pod_pkg::*;
    logic        core_clk;
    logic        rst;
    logic        ref_input;
    logic        rf_input;
    logic        serial_clk;
    logic        serial_last_stage;
    pod_cfg_t    cfg;
    logic        out_sel_high_bit;
    logic        out_sel_low_bit;
    logic [2:0]  ref_mode;
    logic [12:0] ref_div;
    logic [11:0] main_div;
    logic [5:0]  swallow_div;
    logic        cfg_out, od_out, od_oe_n, ref_output, osc_run;
    logic        single_detector_out, single_detector_oe_n, det_ref_n, det_vco_n;
    logic [6:0]  single_current_pct;
    int          mismatches = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          cnt[7] = '{default: 0};
    int          s[7];
    int          d[7];
    logic        cfg_q = 1'h0;
    logic        refo_q = 1'h0;
    int          pct_a[4] = '{70, 80, 90, 100};
    int          pct_b[4] = '{25, 50, 75, 100};
    int          rd[3] = '{5, 3, 13};
    int          er[3] = '{5, 5, 13};
    int          rr[5] = '{16, 8, 4, 2, 1};
    logic [2:0]  pd[6] = '{3'h0, 3'h4, 3'h2, 3'h6, 3'h3, 3'h1};

    pod_far_end u_far (.osc_run(osc_run), .ref_input(ref_input), .rf_input(rf_input));

    pod_top u_dut (
        .core_clk(core_clk), .rst(rst), .ref_input(ref_input), .rf_input(rf_input),
        .serial_clk(serial_clk), .serial_last_stage(serial_last_stage), .cfg(cfg),
        .out_sel_high_bit(out_sel_high_bit), .out_sel_low_bit(out_sel_low_bit),
        .ref_mode(ref_mode), .ref_div(ref_div), .main_div(main_div), .swallow_div(swallow_div),
        .cfg_out(cfg_out), .od_out(od_out), .od_oe_n(od_oe_n), .ref_output(ref_output),
        .osc_run(osc_run), .single_detector_out(single_detector_out),
        .single_detector_oe_n(single_detector_oe_n), .single_current_pct(single_current_pct),
        .det_ref_n(det_ref_n), .det_vco_n(det_vco_n)
    );

    always #2.5 core_clk = ~core_clk;

    // event counters sampled at the falling edge, clear of the edge that launches the outputs;
    // windows are read as differences so nothing is cleared
    always @(negedge core_clk)
    begin
        cycles++;
        cnt[0] += int'(cfg_out === 1'h1 && cfg_q === 1'h0);
        cnt[1] += int'(ref_output === 1'h1 && refo_q === 1'h0);
        cnt[2] += int'(det_ref_n === 1'h0);
        cnt[3] += int'(det_vco_n === 1'h0);
        cnt[4] += int'(single_detector_oe_n === 1'h0 && single_detector_out === 1'h1);
        cnt[5] += int'(single_detector_oe_n === 1'h0 && single_detector_out === 1'h0);
        cnt[6] += int'(single_detector_oe_n === 1'h0);
        cfg_q  <= cfg_out;
        refo_q <= ref_output;
        if (cycles >= 60000)
        begin
            mismatches++;
            final_report();
        end
    end

    task final_report();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    task chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        checks_done++;
        if ((got >= lo && got <= hi) !== 1'h1)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick

    task edges(input logic rf, input int n);
        if (rf)
            repeat (n) @(posedge rf_input);
        else
            repeat (n) @(posedge ref_input);
        @(negedge core_clk);
    endtask : edges

    // count events over a window that starts once the new setting has settled
    task window(input logic rf, input int settle, input int len);
        edges(rf, settle);
        s = cnt;
        edges(rf, len);
        foreach (d[i]) d[i] = cnt[i] - s[i];
    endtask : window

    initial
    begin
        logic b;
        int   e;
        core_clk = 1'h0;
        rst = 1'h1;
        serial_clk = 1'h0;
        serial_last_stage = 1'h0;
        cfg = '0;
        cfg.open_drain_bit = 1'h1;
        {out_sel_high_bit, out_sel_low_bit} = OSEL_SERIAL;
        ref_mode = RMODE_RESET;
        ref_div = REF_DIV_MIN;
        main_div = 12'h002;
        swallow_div = 6'h02;
        void'($urandom(54440));
        tick(16);
        chk(od_oe_n, 1'h0, 1'h0);
        chk(od_out, 1'h0, 1'h0);
        chk({det_ref_n, det_vco_n}, 2'h3, 2'h3);
        chk(single_detector_oe_n, 1'h1, 1'h1);
        rst = 1'h0;
        tick(2);
        // alternate the level so a missed shift, or one on the rising serial edge, always shows
        b = 1'h1;
        repeat (4)
        begin
            serial_last_stage = b;
            serial_clk = 1'h1;
            tick(6);
            chk(cfg_out, !b, !b);
            serial_clk = 1'h0;
            tick(8);
            chk(cfg_out, b, b);
            b = !b;
        end
        {out_sel_high_bit, out_sel_low_bit} = OSEL_PORT;
        repeat (6)
        begin
            cfg.port_bit = 1'($urandom);
            cfg.open_drain_bit = 1'($urandom);
            tick(2);
            chk(cfg_out, cfg.port_bit, cfg.port_bit);
            chk(od_oe_n, cfg.open_drain_bit, cfg.open_drain_bit);
        end
        // the last case is port selection, where the high port bit keeps the fine table
        for (int i = 0; i < 9; i++)
        begin
            {cfg.current_level_hi, cfg.current_level_lo} = i[1:0];
            cfg.port_bit = i[2] | i[3];
            {out_sel_high_bit, out_sel_low_bit} = (i == 8) ? OSEL_PORT : OSEL_VCO;
            tick(3);
            e = (i >= 4 && i < 8) ? pct_b[i % 4] : pct_a[i % 4];
            chk(single_current_pct, e, e);
        end
        cfg.port_bit = 1'h0;
        {out_sel_high_bit, out_sel_low_bit} = OSEL_REF;
        ref_mode = RMODE_XTAL_ON;
        for (int i = 0; i < 3; i++)
        begin
            ref_div = 13'(rd[i]);
            window(1'h0, 2 * er[i], 6 * er[i]);
            chk(d[0], 5, 7);
        end
        cfg.standby_bit = 1'h1;
        window(1'h0, 10, 30);
        chk(d[0], 0, 0);
        chk(osc_run, 1'h1, 1'h1);
        ref_mode = RMODE_XTAL_OFF;
        tick(20);
        chk(osc_run, 1'h0, 1'h0);
        cfg.standby_bit = 1'h0;
        tick(20);
        chk(osc_run, 1'h0, 1'h0);
        ref_mode = RMODE_RESET;
        ref_div = REF_DIV_MIN;
        {out_sel_high_bit, out_sel_low_bit} = OSEL_VCO;
        // main count kept at or above the swallow count, as the counters need
        for (int i = 0; i < 2; i++)
        begin
            main_div = 12'(i + 2);
            swallow_div = (i == 0) ? 6'h02 : 6'h00;
            e = (i + 2) * PRESCALE_RATIO + ((i == 0) ? 2 : 0);
            window(1'h1, 2 * e, 4 * e);
            chk(d[0], 3, 5);
        end
        // modes 7 down to 2: ratios 16, 8, 4, 2, 1, then output disabled
        for (int i = 0; i < 6; i++)
        begin
            ref_mode = 3'(7 - i);
            window(1'h0, 32, (i == 5) ? 32 : 4 * rr[i]);
            chk(d[1], (i == 5) ? 0 : 3, (i == 5) ? 0 : 5);
        end
        // reference pulses outrun the vco pulses, so the vco side lags throughout
        for (int i = 0; i < 6; i++)
        begin
            {cfg.polarity_bit, cfg.detector_select_bit, cfg.standby_bit} = pd[i];
            tick(200);
            s = cnt;
            tick(2000);
            foreach (d[j]) d[j] = cnt[j] - s[j];
            if (pd[i][0] || pd[i][1])
                chk(d[2] + d[3], 0, 0);
            else
                chk(pd[i][2] ? d[3] > d[2] : d[2] > d[3], 1, 1);
            if (!pd[i][1] || pd[i][0])
                chk(d[6], 0, 0);
            else
                chk(pd[i][2] ? d[5] > d[4] : d[4] > d[5], 1, 1);
        end
        final_report();
    end
endmodule : tb
